// ---- src/wpsr_regs.vh ----
`ifndef WPSR_REGS_VH
`define WPSR_REGS_VH
// register address and device select
`define WPSR_CSR_ADDR 8'hff
`define WPSR_TYPE_CODE 4'ha
`define WPSR_TYPE_REG 2'b01
`define WPSR_TYPE_MEM 2'b00
`define WPSR_TYPE_POT 2'b01
// field positions
`define WPSR_BIT_WEL 1
`define WPSR_BIT_RWU 2
`define WPSR_BIT_LKLO 3
`define WPSR_BIT_LKHI 4
// command values
`define WPSR_CMD_SET_WEL 8'h02
`define WPSR_CMD_CLR_ALL 8'h00
`define WPSR_CMD_SET_RWU 8'h06
`define WPSR_RSVD_MASK 8'he1
// reset values
`define WPSR_LOCK_RESET 2'b00
// nonvolatile cycle time
`define WPSR_NV_MS 5
`endif

// ---- src/wpsr_sync.v ----
`timescale 1ns/1ns
`default_nettype none
module wpsr_sync #(
   parameter W = 1
) (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire [W-1:0] din,
   output reg [W-1:0] dout
);
   reg [W-1:0] meta_q;
   always @(posedge clk) begin
      if (reset) begin
         meta_q <= {W{1'b0}};
         dout <= {W{1'b0}};
      end else if (ce) begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule
`default_nettype wire

// ---- src/wpsr_nvcell.v ----
`include "wpsr_regs.vh"
`timescale 1ns/1ns
`default_nettype none
// nonvolatile lock store; the reset leaves contents alone by design
module wpsr_nvcell (
   input wire clk,
   input wire ce,
   input wire wr,
   input wire [1:0] wdata,
   output reg [1:0] rdata
);
   reg [1:0] cell_q;
   initial cell_q = `WPSR_LOCK_RESET;
   always @(posedge clk) begin
      if (ce) begin
         if (wr) begin
            cell_q <= wdata;
         end
         rdata <= cell_q;
      end
   end
endmodule
`default_nettype wire

// ---- src/wpsr_top.v ----
`include "wpsr_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module wpsr_top #(
   parameter CLK_KHZ = 125000,
   parameter NV_CYCLES = `WPSR_NV_MS * CLK_KHZ
) (
   input wire clk,
   input wire reset,
   input wire ce,
   input wire scl_pin,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   input wire write_protect_pin,
   input wire addr_select_pin,
   output reg [7:0] control_status_reg,
   output reg busy,
   output reg mem_wr,
   output reg [7:0] mem_addr,
   output reg [7:0] mem_wdata,
   output reg pot_wr,
   output reg pot_nv,
   output reg [7:0] pot_wdata
);
   // ****************************************
   // input synchronisers
   // ****************************************
   wire [3:0] sync_w;
   wpsr_sync #(.W(4)) u_sync (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .din({scl_pin, sda_in, write_protect_pin, addr_select_pin}),
      .dout(sync_w)
   );
   wire scl_s = sync_w[3];
   wire sda_s = sync_w[2];
   wire wp_s = sync_w[1];
   wire asel_s = sync_w[0];
   reg scl_q, sda_q;
   always @(posedge clk) begin
      if (reset) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_q;
   wire scl_fall = ~scl_s & scl_q;
   wire start_ev = scl_s & scl_q & sda_q & ~sda_s;
   wire stop_ev = scl_s & scl_q & ~sda_q & sda_s;

   // ****************************************
   // state
   // ****************************************
   localparam ST_IDLE = 3'd0;
   localparam ST_DSEL = 3'd1;
   localparam ST_ADDR = 3'd2;
   localparam ST_DATA = 3'd3;
   localparam ST_RD = 3'd4;
   localparam ST_RDACK = 3'd5;
   localparam ST_SKIP = 3'd6;
   localparam NVW = 32;
   localparam [NVW-1:0] NV_LOAD = NV_CYCLES;

   reg [2:0] st_q;
   reg [3:0] bit_q;
   reg [7:0] sh_q;
   reg [1:0] kind_q;
   reg rd_q, ack_q, nack_q, nbytes_q;
   reg [7:0] addr_q;
   reg [7:0] csr_addr_q;
   reg wel_q, rwu_q;
   reg pend_q;
   reg ack_go_q;
   reg [1:0] pend_lock_q;
   reg pend_rwu_q;
   reg csr_pend_q;
   reg [7:0] csr_pend_val_q;
   reg [1:0] mem_cnt_q;
   reg nv_wr;
   reg [NVW-1:0] nv_cnt_q;
   wire [1:0] lock_w;
   reg array_pend_q, pot_pend_q;
   reg [7:0] data_pend_q;

   wpsr_nvcell u_nv (
      .clk(clk),
      .ce(ce),
      .wr(nv_wr),
      .wdata(pend_lock_q),
      .rdata(lock_w)
   );

   // address is protected by lock setting
   function prot;
      input [1:0] lk;
      input [7:0] a;
      begin
         case (lk)
            2'b01: prot = (a[7:6] == 2'b11);
            2'b10: prot = a[7];
            2'b11: prot = 1'b1;
            default: prot = 1'b0;
         endcase
      end
   endfunction

   wire [7:0] csr_w = {3'b000, lock_w, rwu_q, wel_q, 1'b0};
   wire sel_ok = (sh_q[7:4] == `WPSR_TYPE_CODE) && (sh_q[3] == asel_s);

   // ****************************************
   // serial engine and latches
   // ****************************************
   always @(posedge clk) begin
      if (reset) begin
         st_q <= ST_IDLE;
         bit_q <= 4'd0;
         sh_q <= 8'h00;
         kind_q <= 2'b00;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         nack_q <= 1'b0;
         nbytes_q <= 1'b0;
         addr_q <= 8'h00;
         csr_addr_q <= 8'h00;
         wel_q <= 1'b0;
         rwu_q <= 1'b0;
         pend_q <= 1'b0;
         pend_lock_q <= `WPSR_LOCK_RESET;
         pend_rwu_q <= 1'b0;
         ack_go_q <= 1'b0;
         csr_pend_q <= 1'b0;
         csr_pend_val_q <= 8'h00;
         array_pend_q <= 1'b0;
         pot_pend_q <= 1'b0;
         data_pend_q <= 8'h00;
         nv_wr <= 1'b0;
         nv_cnt_q <= {NVW{1'b0}};
         busy <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         control_status_reg <= 8'h00;
         mem_wr <= 1'b0;
         mem_addr <= 8'h00;
         mem_wdata <= 8'h00;
         pot_wr <= 1'b0;
         pot_nv <= 1'b0;
         pot_wdata <= 8'h00;
         mem_cnt_q <= 2'd0;
      end else if (ce) begin
         nv_wr <= 1'b0;
         mem_wr <= 1'b0;
         pot_wr <= 1'b0;
         control_status_reg <= csr_w;
         ack_go_q <= 1'b0;
         // nonvolatile busy cycle; inputs ignored meanwhile
         if (busy) begin
            if (nv_cnt_q == {NVW{1'b0}}) begin
               busy <= 1'b0;
               nv_wr <= pend_q;
               pend_q <= 1'b0;
            end else begin
               nv_cnt_q <= nv_cnt_q - 1'b1;
            end
         end else if (stop_ev) begin
            st_q <= ST_IDLE;
            sda_oe <= 1'b0;
            if (csr_pend_q) begin
               csr_pend_q <= 1'b0;
               if (csr_pend_val_q == `WPSR_CMD_CLR_ALL) begin
                  wel_q <= 1'b0;
                  rwu_q <= 1'b0;
               end else if (csr_pend_val_q == `WPSR_CMD_SET_WEL && !rwu_q) begin
                  wel_q <= 1'b1;
               end else if (csr_pend_val_q == `WPSR_CMD_SET_RWU) begin
                  rwu_q <= wel_q;
               end else if (rwu_q) begin
                  // lock update: unlock bit set keeps locks, else nv cycle unless protect pin is high
                  if (csr_pend_val_q[`WPSR_BIT_RWU]) begin
                     rwu_q <= 1'b1;
                  end else begin
                     rwu_q <= 1'b0;
                     if (!wp_s) begin
                        pend_q <= 1'b1;
                        pend_lock_q <= csr_pend_val_q[`WPSR_BIT_LKHI:`WPSR_BIT_LKLO];
                        busy <= 1'b1;
                        nv_cnt_q <= NV_LOAD;
                     end
                  end
               end
            end
            if (array_pend_q) begin
               array_pend_q <= 1'b0;
               mem_wr <= 1'b1;
               mem_addr <= addr_q;
               mem_wdata <= data_pend_q;
               busy <= 1'b1;
               nv_cnt_q <= NV_LOAD;
            end
            if (pot_pend_q) begin
               pot_pend_q <= 1'b0;
               pot_wr <= 1'b1;
               pot_nv <= ~wp_s;
               pot_wdata <= data_pend_q;
            end
         end else if (start_ev) begin
            st_q <= ST_DSEL;
            bit_q <= 4'd0;
            sda_oe <= 1'b0;
            nbytes_q <= 1'b0;
            csr_pend_q <= 1'b0;
            array_pend_q <= 1'b0;
            pot_pend_q <= 1'b0;
         end else if (st_q != ST_IDLE && st_q != ST_SKIP) begin
            if (scl_rise && bit_q < 4'd8) begin
               sh_q <= {sh_q[6:0], sda_s};
               bit_q <= bit_q + 1'b1;
            end else if (scl_rise && bit_q == 4'd8) begin
               nack_q <= sda_s;
               bit_q <= 4'd9;
            end else if (scl_fall && bit_q == 4'd8 && st_q != ST_RD) begin
               // ack goes out a cycle later, once the decision below has landed
               ack_go_q <= 1'b1;
            end else if (scl_fall && bit_q == 4'd9) begin
               sda_oe <= 1'b0;
               bit_q <= 4'd0;
               if (!ack_q && st_q != ST_RD) begin
                  st_q <= ST_SKIP;
               end else if (st_q == ST_RD && !nbytes_q) begin
                  // select ack done: first register bit goes out now
                  nbytes_q <= 1'b1;
                  sda_oe <= ~csr_w[7];
                  sda_out <= 1'b0;
               end else if (st_q == ST_RD) begin
                  st_q <= ST_SKIP;
               end
            end else if (scl_fall && bit_q == 4'd8) begin
               sda_oe <= 1'b0;
            end
            if (ack_go_q) begin
               sda_oe <= ack_q;
               sda_out <= 1'b0;
            end
            // decide ack at eighth bit of each byte
            if (scl_fall && bit_q == 4'd8 && st_q != ST_RD) begin
               case (st_q)
                  ST_DSEL: begin
                     ack_q <= sel_ok;
                     kind_q <= sh_q[2:1];
                     rd_q <= sh_q[0];
                     if (sel_ok && sh_q[0]) begin
                        st_q <= ST_RD;
                     end else begin
                        st_q <= ST_ADDR;
                     end
                  end
                  ST_ADDR: begin
                     addr_q <= sh_q;
                     st_q <= ST_DATA;
                     if (kind_q == `WPSR_TYPE_MEM && prot(lock_w, sh_q)) begin
                        ack_q <= 1'b0;
                        rwu_q <= 1'b0;
                     end else begin
                        ack_q <= 1'b1;
                     end
                     if (kind_q == `WPSR_TYPE_REG) csr_addr_q <= sh_q;
                  end
                  ST_DATA: begin
                     nbytes_q <= 1'b1;
                     data_pend_q <= sh_q;
                     if (!wel_q && sh_q != `WPSR_CMD_SET_WEL) begin
                        ack_q <= 1'b0;
                     end else if (nbytes_q && kind_q == `WPSR_TYPE_REG) begin
                        ack_q <= 1'b0;
                        csr_pend_q <= 1'b0;
                     end else if (kind_q == `WPSR_TYPE_REG) begin
                        ack_q <= (addr_q == `WPSR_CSR_ADDR);
                        csr_pend_q <= (addr_q == `WPSR_CSR_ADDR);
                        csr_pend_val_q <= sh_q & ~`WPSR_RSVD_MASK;
                     end else if (kind_q == `WPSR_TYPE_MEM) begin
                        ack_q <= ~wp_s && ~prot(lock_w, addr_q);
                        array_pend_q <= ~wp_s && ~prot(lock_w, addr_q);
                     end else begin
                        ack_q <= (lock_w == 2'b00);
                        pot_pend_q <= (lock_w == 2'b00);
                     end
                  end
                  default: ack_q <= 1'b0;
               endcase
            end
            // read: shift register contents out, reads leave latches alone
            if (st_q == ST_RD && scl_fall && bit_q < 4'd8) begin
               sda_oe <= ~csr_w[3'd7 - bit_q[2:0]];
               sda_out <= 1'b0;
            end
            if (st_q == ST_RD && scl_fall && bit_q == 4'd8) begin
               sda_oe <= 1'b0;
            end
         end
         mem_cnt_q <= mem_cnt_q;
      end
   end
endmodule
`default_nettype wire

// ---- bench/wpsr_chk.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************
// protection checks
// ****************
module wpsr_chk (
   input wire clk,
   input wire reset,
   input wire [7:0] control_status_reg,
   input wire busy,
   input wire mem_wr,
   input wire [7:0] mem_addr,
   input wire pot_wr,
   input wire pot_nv,
   input wire write_protect_pin
);
   wire [1:0] lk = control_status_reg[4:3];
   wire [7:0] ma = mem_addr;
   wire wp = write_protect_pin;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   chk_reset_clear: assert property ($fell(reset) |-> !busy && control_status_reg[2:1] == 2'b00)
      else $error("latches not clear after reset");
   chk_rsvd_zero: assert property ((control_status_reg & 8'he1) == 8'h00)
      else $error("reserved bits not zero");
   chk_pot_lock: assert property (pot_wr |-> lk == 2'b00)
      else $error("wiper write while locked");
   chk_pot_wp: assert property (pot_wr && wp && $past(wp, 4) |-> !pot_nv)
      else $error("nonvolatile wiper write under protect pin");
   chk_mem_wp: assert property (mem_wr |-> !(wp && $past(wp, 4)))
      else $error("array write under protect pin");
   chk_mem_range: assert property (mem_wr |-> !(lk == 2'b11 || lk == 2'b10 && ma[7]
      || lk == 2'b01 && ma[7:6] == 2'b11))
      else $error("array write into locked range");
   chk_mem_enable: assert property (mem_wr |-> control_status_reg[1])
      else $error("array write without write enable");
   chk_unlock_order: assert property ($rose(control_status_reg[2]) |-> $past(control_status_reg[1]))
      else $error("unlock set before write enable");
   chk_lock_gate: assert property (!$stable(lk) |-> $past(busy, 4))
      else $error("lock bits changed without unlock");
   chk_busy_span: assert property ($rose(busy) |-> busy [*8] ##[1:1000] !busy)
      else $error("nonvolatile cycle length wrong");
endmodule
bind wpsr_top wpsr_chk chk (.clk(clk), .reset(reset), .control_status_reg(control_status_reg),
   .busy(busy), .mem_wr(mem_wr), .mem_addr(mem_addr), .pot_wr(pot_wr), .pot_nv(pot_nv),
   .write_protect_pin(write_protect_pin));
`default_nettype wire

// ---- bench/wpsr_host.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************
// two-wire host model
// ****************
module wpsr_host (
   input wire clk,
   input wire sda,
   output logic scl,
   output logic sda_low
);
   // scl rests high between frames, only pulled low inside them
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic half(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic hb(input logic b, output logic r);
      @(posedge clk);
      #1 sda_low = !b;
      half(4);
      scl = 1'b1;
      repeat (3) @(posedge clk);
      r = sda;
      half(2);
      scl = 1'b0;
   endtask
   task automatic start();
      @(posedge clk);
      #1 sda_low = 1'b0;
      half(5);
      scl = 1'b1;
      half(5);
      sda_low = 1'b1;
      half(5);
      scl = 1'b0;
   endtask
   task automatic stop();
      @(posedge clk);
      #1 sda_low = 1'b1;
      half(5);
      scl = 1'b1;
      half(5);
      sda_low = 1'b0;
      half(5);
   endtask
   task automatic xb(input logic [7:0] d, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--) hb(d[i], r);
      hb(1'b1, r);
      a = !r;
   endtask
   task automatic wr(input logic [7:0] ds, a, d, input logic two, output logic [3:0] k);
      start();
      xb(ds, k[3]);
      xb(a, k[2]);
      xb(d, k[1]);
      k[0] = 1'b0;
      if (two) xb(d, k[0]);
      stop();
   endtask
   task automatic rd(input logic [7:0] dw, dr, output logic [7:0] q);
      logic r;
      start();
      xb(dw, r);
      xb(8'hff, r);
      start();
      xb(dr, r);
      for (int i = 7; i >= 0; i--) hb(1'b1, q[i]);
      hb(1'b1, r);
      stop();
   endtask
endmodule
`default_nettype wire

// ---- bench/wpsr_top_test.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****************
// register bench
// ****************
module wpsr_top_test;
   localparam logic [7:0] CW = 8'ha2, CR = 8'ha3, MW = 8'ha0;
   logic clk, reset, wp, asel, bsy;
   logic [7:0] nwr = 8'h00, lastaddr = 8'h00, lastdata = 8'h00, lastpot = 8'h00, q;
   logic [3:0] k;
   int fail_count = 0, n_compared = 0;
   wire scl, host_low, sda_out, sda_oe, busy, mem_wr, pot_wr, pot_nv;
   wire [7:0] csr, mem_addr, mem_wdata, pot_wdata;
   wire sda = !(host_low || (sda_oe && !sda_out)); // pulled up when nobody drives
   wpsr_top #(.NV_CYCLES(20)) dut (.clk(clk), .reset(reset), .ce(1'b1), .scl_pin(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_pin(wp),
      .addr_select_pin(asel), .control_status_reg(csr), .busy(busy), .mem_wr(mem_wr),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .pot_wr(pot_wr), .pot_nv(pot_nv),
      .pot_wdata(pot_wdata));
   wpsr_host h (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) if (mem_wr === 1'b1) begin
      nwr <= nwr + 8'h01;
      lastaddr <= mem_addr;
      lastdata <= mem_wdata;
   end
   always @(posedge clk) if (pot_wr === 1'b1) lastpot <= pot_wdata;
   task automatic chk(input logic [7:0] seen, exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic w(input logic [7:0] ds, a, d, input logic two);
      h.wr(ds, a, d, two, k);
      repeat (2) @(posedge clk);
      #1 bsy = busy;
      for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
      // lock bits reach the register copy a few cycles after busy drops
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic wc(input logic [7:0] d);
      w(CW, 8'hff, d, 1'b0);
   endtask
   task automatic report_and_stop();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
   initial begin
      reset = 1'b1;
      wp = 1'b0;
      asel = 1'b0;
      repeat (5) @(posedge clk);
      #1 reset = 1'b0;
      repeat (3) @(posedge clk);
      chk(csr, 8'h00);
      w(MW, 8'h10, 8'h55, 1'b0);
      chk(k[1], 1'b0);
      chk(nwr, 8'h00);
      wc(8'h02);
      chk(csr, 8'h02);
      chk(bsy, 1'b0);
      h.rd(CW, CR, q);
      chk(q, 8'h02);
      wc(8'h00);
      chk(csr, 8'h00);
      wc(8'h06);
      chk(csr, 8'h00);
      $display("test enable latch done");
      wc(8'h02);
      wc(8'h06);
      chk(csr, 8'h06);
      h.rd(CW, CR, q);
      chk(q, 8'h06);
      wc(8'h1e);
      chk(csr, 8'h06);
      wc(8'h0a);
      chk(bsy, 1'b1);
      chk(csr, 8'h0a);
      wc(8'h12);
      chk(csr, 8'h0a);
      $display("test lock sequence done");
      w(MW, 8'hc0, 8'h5a, 1'b0);
      chk(k[2], 1'b0);
      chk(nwr, 8'h00);
      w(MW, 8'hbf, 8'h5a, 1'b0);
      chk(nwr, 8'h01);
      chk(lastaddr, 8'hbf);
      chk(lastdata, 8'h5a);
      w(CW, 8'hff, 8'h00, 1'b1);
      chk(k[0], 1'b0);
      chk(csr, 8'h0a);
      w(8'haa, 8'hff, 8'h00, 1'b0);
      chk(k[3], 1'b0);
      chk(csr, 8'h0a);
      $display("test array lock done");
      wp = 1'b1;
      wc(8'h02);
      wc(8'h06);
      wc(8'h02);
      chk(csr & 8'h1a, 8'h0a);
      w(MW, 8'h10, 8'h33, 1'b0);
      chk(nwr, 8'h01);
      wc(8'h00);
      chk(csr & 8'h1a, 8'h08);
      wp = 1'b0;
      wc(8'h02);
      wc(8'h06);
      wc(8'h02);
      chk(csr, 8'h02);
      w(MW, 8'hc0, 8'h44, 1'b0);
      chk(nwr, 8'h02);
      w(8'ha4, 8'h00, 8'h77, 1'b0);
      chk(lastpot, 8'h77);
      $display("test protect pin done");
      report_and_stop();
   end
endmodule
`default_nettype wire
